// file: rtl/rcf_reset_seq.sv
`timescale 1ns/1ns

// Contract
// - Power-up delay after pulse, then oscillator settle
// - Delay by oscillator mode; none if external, disabled
// - Delays run regardless of external clear pin
// - Expired delays: run immediately on clear release
// - Brown-out flag bit 0, cleared by brown-out
// - Brown-out flag meaningless when detector disabled
// - Power-on flag bit 1, zeroed only by power-on
// - Power-up delay holds reset 72 ms
// - Brown-out during delay restarts the delay
// - Detector enable bit switches brown-out detection
module rcf_reset_seq
	import rcf_pkg::*;
#(
	parameter int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_CYCLES_DEF,
	parameter int OST_CYCLES  = OST_CYCLES_DEF
) (
	// Clock and power-on reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Reset sources, asynchronous pins
	input  wire logic              power_on_pulse,
	input  wire logic              brownout_detect,
	input  wire logic              external_clear_n,
	// Configuration word
	input  wire rcf_cfg_t          cfg,
	// Core reset and status
	output logic                   core_reset_n,
	output logic                   timeouts_expired,
	output logic                   irq,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest
);

	// Synchroniser stages
	logic            por_meta_reg;
	logic            por_sync_reg;
	logic            bo_meta_reg;
	logic            bo_sync_reg;
	logic            clr_meta_reg;
	logic            clr_sync_reg;

	// Sequencer
	rcf_seq_t        seq_reg;
	rcf_seq_t        seq_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic            bo_active;
	logic            bo_prev_reg;
	logic            clr_prev_reg;

	// Registers
	logic            bo_flag_n_reg;
	logic            por_flag_n_reg;
	logic [EV_W-1:0] ev_stat_reg;
	logic [EV_W-1:0] ev_en_reg;
	logic [EV_W-1:0] ev_set;
	logic            core_reset_n_next;

	// Bus handshake
	logic            bus_take;
	logic            wr_take;

	// Register map seen by software, byte addresses:
	//   sequencer status  - read only, live view of the chain
	//     bits 1:0  current stage of the delay chain
	//     bit  2    every delay stage has run out
	//     bit  3    core released from reset
	//     bit  4    qualified brown-out seen right now
	//     bit  5    synchronised level of the clear pin
	//   event status      - read only, sticky event bits
	//   event clear       - write only, ones clear status bits
	//   event enable      - read and write, masks the interrupt
	//   cause flags       - read and write, two active-low flags
	// Event bits, same layout in status, clear and enable:
	//   bit 0  brown-out became active
	//   bit 1  delay chain reached the run stage
	//   bit 2  core reset released
	//   bit 3  clear pin fell
	// Unmapped reads return zero and unmapped writes vanish, so
	// software that probes the map never disturbs the chain.

	// Pin inputs are asynchronous to the oscillator clock.
	// Two flops per pin keep metastability out of the chain.
	// The cost is two cycles of latency on every pin, which is
	// far below any delay the chain itself applies.
	// Power-on pulse syncs reset to the active level so the
	// chain cannot start before the pulse is seen to end.
	// Two flops per pin; only the second stage is read by logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_meta_reg <= 1'h1;
			por_sync_reg <= 1'h1;
			bo_meta_reg  <= 1'h0;
			bo_sync_reg  <= 1'h0;
			clr_meta_reg <= 1'h0;
			clr_sync_reg <= 1'h0;
		end else begin
			por_meta_reg <= power_on_pulse;
			por_sync_reg <= por_meta_reg;
			bo_meta_reg  <= brownout_detect;
			bo_sync_reg  <= bo_meta_reg;
			clr_meta_reg <= external_clear_n;
			clr_sync_reg <= clr_meta_reg;
		end
	end

	// Detector output counts only when the enable bit is set
	assign bo_active = bo_sync_reg && cfg.brownout_detector_enable;

	// Delay chain overview:
	//   hold   - waits for the power-on pulse to end
	//   power  - optional power-up delay, one shared counter
	//   settle - crystal settling, skipped for driven clocks
	//   run    - all delays done, core may leave reset
	// One counter serves both timed stages; it is cleared on
	// every stage change so each stage counts from zero.
	// A qualified brown-out sends the chain back to hold from
	// any stage, so a dip during the power-up delay restarts
	// the whole chain instead of resuming a partial count.
	// The clear pin is deliberately kept out of this logic: the
	// delays run out while the pin is low, and release then
	// follows the pin alone.
	// Next state of the delay chain; the clear pin never enters here
	always_comb begin
		seq_next = seq_reg;
		cnt_next = cnt_reg;
		if (bo_active) begin
			// Brown-out drops back to hold and re-arms the delay
			seq_next = SEQ_HOLD;
			cnt_next = '0;
		end else begin
			unique case (seq_reg)
				SEQ_HOLD: begin
					// Delay starts only once the power-on pulse is gone
					if (!por_sync_reg) begin
						cnt_next = '0;
						if (!cfg.power_up_delay_enable_n)
							seq_next = SEQ_POWER_UP_DELAY_TIMER;
						else if (rcf_needs_settle(cfg.osc_mode))
							seq_next = SEQ_OST;
						else
							seq_next = SEQ_RUN;
					end
				end
				SEQ_POWER_UP_DELAY_TIMER: begin
					if (cnt_reg == CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1)) begin
						cnt_next = '0;
						// Settle follows only after the full power-up delay
						seq_next = rcf_needs_settle(cfg.osc_mode) ? SEQ_OST : SEQ_RUN;
					end else begin
						cnt_next = cnt_reg + CNT_W'(1);
					end
				end
				SEQ_OST: begin
					if (cnt_reg == CNT_W'(OST_CYCLES - 1)) begin
						cnt_next = '0;
						seq_next = SEQ_RUN;
					end else begin
						cnt_next = cnt_reg + CNT_W'(1);
					end
				end
				SEQ_RUN: begin
					cnt_next = '0;
				end
			endcase
		end
	end

	// Sequencer state and counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg <= SEQ_HOLD;
			cnt_reg <= '0;
		end else begin
			seq_reg <= seq_next;
			cnt_reg <= cnt_next;
		end
	end

	// Core runs when every stage is done and the clear pin is high
	assign core_reset_n_next = (seq_next == SEQ_RUN) && clr_sync_reg;

	// Registered outputs of the sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_reset_n     <= 1'h0;
			timeouts_expired <= 1'h0;
		end else begin
			core_reset_n     <= core_reset_n_next;
			timeouts_expired <= (seq_next == SEQ_RUN);
		end
	end

	// Edge history for event detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bo_prev_reg  <= 1'h0;
			clr_prev_reg <= 1'h0;
		end else begin
			bo_prev_reg  <= bo_active;
			clr_prev_reg <= clr_sync_reg;
		end
	end

	// One-cycle events feeding the sticky status
	always_comb begin
		ev_set               = '0;
		ev_set[EV_BROWNOUT]  = bo_active && !bo_prev_reg;
		ev_set[EV_TIMEOUT]   = (seq_next == SEQ_RUN) && (seq_reg != SEQ_RUN);
		ev_set[EV_RELEASE]   = core_reset_n_next && !core_reset_n;
		ev_set[EV_CLEAR_PIN] = clr_prev_reg && !clr_sync_reg;
	end

	// Bus timing: waitrequest idles high and drops for one cycle
	// after the first edge that sees a request. The request is
	// taken at the following edge, so every access costs two
	// cycles. Read data is loaded in the wait cycle and holds
	// until the next read, so the master may sample it at the
	// accept edge. Only byte lane 0 carries register bits; a
	// write with that lane disabled changes nothing.
	// Bus request is accepted on the edge where waitrequest is low
	assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
	assign wr_take  = bus_take && avs_write && avs_byteenable[0];

	// Brown-out flag: hardware clear beats a software write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bo_flag_n_reg <= BO_FLAG_RST;
		end else if (bo_active) begin
			bo_flag_n_reg <= 1'h0;
		end else if (wr_take && avs_address == ADDR_CAUSE) begin
			bo_flag_n_reg <= avs_writedata[CAUSE_BO_BIT];
		end
	end

	// Power-on flag: only the power-on reset forces it low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_flag_n_reg <= POR_FLAG_RST;
		end else if (wr_take && avs_address == ADDR_CAUSE) begin
			por_flag_n_reg <= avs_writedata[CAUSE_POR_BIT];
		end
	end

	// Cause flags are active low. Software writes ones after a
	// power-on and later reads a zero to learn the reset cause.
	// With the detector disabled the brown-out flag is left to
	// software alone and carries no meaning.
	// Sticky event status; a new event wins over a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_stat_reg <= EV_RST;
		end else if (wr_take && avs_address == ADDR_IRQ_CLEAR) begin
			ev_stat_reg <= (ev_stat_reg & ~avs_writedata[EV_W-1:0]) | ev_set;
		end else begin
			ev_stat_reg <= ev_stat_reg | ev_set;
		end
	end

	// Event enable mask
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_en_reg <= EV_RST;
		end else if (wr_take && avs_address == ADDR_IRQ_EN) begin
			ev_en_reg <= avs_writedata[EV_W-1:0];
		end
	end

	// The interrupt is a registered level so the output comes
	// straight from a flop; it lags status by one cycle, which
	// software never sees through the two-cycle bus.
	// Level interrupt, one cycle behind the status it reflects
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'h0;
		end else begin
			irq <= |(ev_stat_reg & ev_en_reg);
		end
	end

	// One wait state: waitrequest drops for exactly the accept edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'h1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// Read data loaded while waitrequest is high; unmapped reads as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				ADDR_SEQ_STAT:
					avs_readdata <= {26'h0, clr_sync_reg, bo_active, core_reset_n, timeouts_expired,
						seq_reg};
				ADDR_IRQ_STAT:
					avs_readdata <= {28'h0, ev_stat_reg};
				ADDR_IRQ_EN:
					avs_readdata <= {28'h0, ev_en_reg};
				ADDR_CAUSE:
					avs_readdata <= {30'h0, por_flag_n_reg, bo_flag_n_reg};
				default:
					avs_readdata <= '0;
			endcase
		end
	end

endmodule : rcf_reset_seq

// file: rtl/rcf_pkg.sv
package rcf_pkg;

	// Clock and time figures
	localparam int CLK_HZ          = 10_000_000;
	localparam int POWER_UP_DELAY_TIMER_TIME_MS    = 72;
	localparam int POWER_UP_DELAY_TIMER_CYCLES_DEF = POWER_UP_DELAY_TIMER_TIME_MS * (CLK_HZ / 1000);
	localparam int OST_CYCLES_DEF  = 1024;
	localparam int CNT_W           = 32;

	// Register map, byte addresses on a 12-bit Avalon address
	localparam int          ADDR_W         = 12;
	localparam int          CAUSE_INDEX    = 'h8E;
	localparam logic [11:0] ADDR_SEQ_STAT  = 12'h000;
	localparam logic [11:0] ADDR_IRQ_STAT  = 12'h004;
	localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h008;
	localparam logic [11:0] ADDR_IRQ_EN    = 12'h00C;
	localparam logic [11:0] ADDR_CAUSE     = 12'(CAUSE_INDEX * 4);

	// Cause register fields and reset values
	localparam int         CAUSE_BO_BIT  = 0;
	localparam int         CAUSE_POR_BIT = 1;
	localparam logic       BO_FLAG_RST   = 1'h0;
	localparam logic       POR_FLAG_RST  = 1'h0;

	// Event bits, shared by status, clear and enable registers
	localparam int         EV_W          = 4;
	localparam int         EV_BROWNOUT   = 0;
	localparam int         EV_TIMEOUT    = 1;
	localparam int         EV_RELEASE    = 2;
	localparam int         EV_CLEAR_PIN  = 3;
	localparam logic [3:0] EV_RST        = 4'h0;

	// Oscillator configurations
	typedef enum logic [2:0] {
		OSC_LP,
		OSC_XT,
		OSC_HS,
		OSC_EXT_CLOCK,
		OSC_RC,
		OSC_INTERNAL
	} rcf_osc_mode_t;

	// Configuration word fields, static while running
	typedef struct packed {
		logic          brownout_detector_enable;
		logic          power_up_delay_enable_n;
		rcf_osc_mode_t osc_mode;
	} rcf_cfg_t;

	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_POWER_UP_DELAY_TIMER,
		SEQ_OST,
		SEQ_RUN
	} rcf_seq_t;

	// Crystal modes need settling time; driven clocks do not
	function automatic logic rcf_needs_settle(input rcf_osc_mode_t m);
		return (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
	endfunction : rcf_needs_settle

endpackage : rcf_pkg

// file: dv/rcf_checker.sv
`timescale 1ns/1ns
module rcf_checker
	import rcf_pkg::*;
(
	// Clock, reset and pins
	input wire logic     clk,
	input wire logic     rst_n,
	input wire logic     power_on_pulse,
	input wire logic     brownout_detect,
	input wire logic     external_clear_n,
	input wire rcf_cfg_t cfg,
	// Outputs watched
	input wire logic     core_reset_n,
	input wire logic     timeouts_expired,
	input wire logic     irq,
	input wire logic     avs_read,
	input wire logic     avs_waitrequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Qualified brown-out; windows allow two sync flops plus one register
	logic bo;
	assign bo = brownout_detect && cfg.brownout_detector_enable;
	core_a: assert property (core_reset_n |-> timeouts_expired) else $error("core released early");
	clr_hold_a: assert property (!external_clear_n [*4] |-> !core_reset_n) else $error("clear pin ignored");
	bo_hold_a: assert property (bo [*4] |-> !timeouts_expired) else $error("brownout ignored");
	release_a: assert property ($rose(external_clear_n) && timeouts_expired ##1
		(external_clear_n && timeouts_expired) [*3] |-> core_reset_n) else $error("late release");
	no_delay_a: assert property ($fell(power_on_pulse) && cfg.power_up_delay_enable_n && cfg.osc_mode == OSC_EXT_CLOCK
		##1 (!power_on_pulse && !brownout_detect) [*4] |-> timeouts_expired) else $error("delay seen");
	delay_a: assert property ($fell(power_on_pulse) && !cfg.power_up_delay_enable_n |-> !timeouts_expired [*8])
		else $error("delay too short");
	ack_a: assert property ($rose(avs_read) |=> !avs_waitrequest) else $error("no read answer");
	wait_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
	// Main scenarios reached
	cover property ($rose(core_reset_n));
	cover property ($rose(irq));
	cover property (bo ##1 !bo);
endmodule : rcf_checker

bind rcf_reset_seq rcf_checker rcf_checker_i (.clk(clk), .rst_n(rst_n), .power_on_pulse(power_on_pulse),
	.brownout_detect(brownout_detect), .external_clear_n(external_clear_n), .cfg(cfg), .core_reset_n(core_reset_n),
	.timeouts_expired(timeouts_expired), .irq(irq), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest));

// file: dv/rcf_reset_seq_tb.sv
`timescale 1ns/1ns
module rcf_reset_seq_tb_top
	import rcf_pkg::*;
;
	localparam int PW = 20;
	localparam int OS = 8;
	// Bench signals
	logic        clk = 1'b0;
	logic        rst_n, pulse, bo, clr, rd, wr, core, te, irq, wt;
	logic [11:0] addr;
	logic [31:0] wd, rdat, q, rv;
	rcf_cfg_t    cfg;
	int          n_errors, samples_checked, n, i;

	rcf_reset_seq #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .OST_CYCLES(OS)) rcf_reset_seq_i (.clk(clk), .rst_n(rst_n),
		.power_on_pulse(pulse), .brownout_detect(bo), .external_clear_n(clr), .cfg(cfg), .core_reset_n(core),
		.timeouts_expired(te), .irq(irq), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt));

	// 10 MHz clock
	always #50 clk = ~clk;

	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// One Avalon access; a gap edge follows so requests never merge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (wt === 1'b0) break;
		end
		r = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k == 50) begin
			n_errors++;
			finish_test();
		end
		@(posedge clk);
	endtask : bus

	// Count edges until the delay chain is done
	task automatic wait_te(output int c);
		for (c = 0; c < 2000; c++) begin
			@(posedge clk);
			if (te === 1'b1) break;
		end
		if (c == 2000) begin
			n_errors++;
			finish_test();
		end
	endtask : wait_te

	task automatic por(input rcf_cfg_t c);
		rst_n <= 1'b0;
		pulse <= 1'b1;
		cfg <= c;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : por

	// Main sequence
	initial begin
		{rst_n, pulse, bo, clr, rd, wr, addr, wd} = '0;
		cfg = '{1'b1, 1'b0, OSC_XT};
		void'($urandom(32'h20d9));
		por(cfg);
		bus(0, ADDR_CAUSE, 0, q); chk("cause", 0, q);
		bus(1, ADDR_IRQ_EN, 32'hF, q);
		bus(1, ADDR_CAUSE, 32'h3, q); bus(0, ADDR_CAUSE, 0, q); chk("cause", 32'h3, q);
		clr <= 1'b0;
		pulse <= 1'b0;
		wait_te(n); chk("chain", 1, 32'(n >= PW + OS && n <= PW + OS + 6));
		repeat (4) @(posedge clk);
		chk("core", 0, core);
		clr <= 1'b1;
		repeat (2) @(posedge clk);
		chk("core", 0, core);
		@(posedge clk);
		@(posedge clk); chk("core", 1, core);
		bus(0, ADDR_SEQ_STAT, 0, q); chk("seq", 32'h2F, q);
		// No clear pin fall yet: only chain done and core release are pending
		bus(0, ADDR_IRQ_STAT, 0, q); chk("stat", 32'h6, q);
		chk("irq", 1, irq);
		bus(1, ADDR_IRQ_EN, 0, q); @(posedge clk); chk("irq", 0, irq);
		bus(1, ADDR_IRQ_EN, 32'hF, q); @(posedge clk); chk("irq", 1, irq);
		bus(1, ADDR_IRQ_CLEAR, 32'hE, q); @(posedge clk); chk("irq", 0, irq);
		// Random enables and unmapped places
		for (i = 0; i < 6; i++) begin
			rv = $urandom;
			bus(1, ADDR_IRQ_EN, rv, q); bus(0, ADDR_IRQ_EN, 0, q); chk("en", rv & 32'hF, q);
			bus(1, 12'h100 + 12'($urandom & 32'hFC), rv, q); bus(0, 12'h1FC, 0, q); chk("gap", 0, q);
		end
		// Brown-out clears its flag only and restarts the chain
		bo <= 1'b1;
		repeat (5) @(posedge clk);
		bo <= 1'b0;
		bus(0, ADDR_CAUSE, 0, q); chk("cause", 32'h2, q);
		chk("te", 0, te);
		repeat (10) @(posedge clk);
		bo <= 1'b1;
		@(posedge clk);
		bo <= 1'b0;
		wait_te(n); chk("chain", 1, 32'(n >= PW + OS && n <= PW + OS + 6));
		cfg.brownout_detector_enable <= 1'b0;
		bo <= 1'b1;
		repeat (6) @(posedge clk);
		bo <= 1'b0;
		chk("te", 1, te);
		// Brown-out, chain done and release events are now pending
		bus(0, ADDR_IRQ_STAT, 0, q); chk("stat", 32'h7, q);
		clr <= 1'b0;
		repeat (4) @(posedge clk);
		bus(0, ADDR_IRQ_STAT, 0, q); chk("stat", 32'hF, q);
		chk("core", 0, core);
		// Driven clock with no delay
		por('{1'b1, 1'b1, OSC_EXT_CLOCK});
		bus(0, ADDR_CAUSE, 0, q); chk("cause", 0, q);
		pulse <= 1'b0;
		wait_te(n); chk("fast", 1, 32'(n <= 6));
		finish_test();
	end
endmodule : rcf_reset_seq_tb_top
